/* File: verilog/system_clock_source_select.sv */
// Behaviour
// - system clock follows external oscillator only when source select bit is 1
// - external clock stays available to peripherals while internal drives system
// - source may switch on the fly; software selects only settled oscillators
// - one internal control write enables internal oscillator and sets its divider
// - hardware sets crystal valid flag once oscillator settles; read-only
// - mode 00x turns external oscillator circuit off
// - mode 010 passes CMOS clock from first crystal pin undivided
// - after reset internal oscillator is the system clock source
// - internal clock divided by 1, 2, 4 or 8 per divider field
// - bit 7 of internal control enables internal oscillator
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module system_clock_source_select
  import sysclk_sel_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic int_osc_in,
  input wire logic ext_clock_pin_a,
  input wire logic ext_osc_settled,
  output logic sysclk_out,
  output logic periph_ext_clk,
  output logic int_osc_enable,
  output logic [2:0] ext_osc_mode,
  output logic [2:0] ext_osc_freq_ctrl
);

  typedef struct packed {
    logic int_en;
    logic int_rdy;
    logic [1:0] int_div;
    logic src_sel;
    logic xtal_valid;
    logic [2:0] ext_mode;
    logic [2:0] ext_freq;
    logic [7:0] rdata;
    logic sysclk;
    logic periph_clk;
  } sel_state_t;

  localparam sel_state_t ST_RST = '{
    int_en: INT_OSC_CTRL_RST[INT_EN_BIT],
    int_rdy: INT_OSC_CTRL_RST[INT_RDY_BIT],
    int_div: INT_OSC_CTRL_RST[INT_DIV_LSB +: 2],
    src_sel: CLOCK_SELECT_RST[SRC_SEL_BIT],
    xtal_valid: EXT_OSC_CTRL_RST[XTAL_VALID_BIT],
    ext_mode: EXT_OSC_CTRL_RST[EXT_MODE_LSB +: 3],
    ext_freq: EXT_OSC_CTRL_RST[EXT_FREQ_LSB +: 3],
    rdata: 8'h00,
    sysclk: 1'b0,
    periph_clk: 1'b0
  };

  sel_state_t s_q;
  sel_state_t s_d;
  logic int_div_clk;
  logic ext_div_clk;
  logic [1:0] ext_ratio;
  logic wr_int;
  logic wr_sel;
  logic wr_ext;

  ////////////////////////////////////////////////////////////////////////////
  // clock dividers on the sampled oscillator waveforms

  clk_ratio_div u_int_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_in(int_osc_in),
    .ratio_sel(int_ratio(s_q.int_div)),
    .clk_out(int_div_clk)
  );

  assign ext_ratio = ext_is_half(s_q.ext_mode) ? RATIO_HALF : RATIO_PASS;

  clk_ratio_div u_ext_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_in(ext_clock_pin_a),
    .ratio_sel(ext_ratio),
    .clk_out(ext_div_clk)
  );

  // write decode
  assign wr_int = reg_wr && (reg_addr == INT_OSC_CTRL_OFF);
  assign wr_sel = reg_wr && (reg_addr == CLOCK_SELECT_OFF);
  assign wr_ext = reg_wr && (reg_addr == EXT_OSC_CTRL_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // next state: register writes, flags, clock selection, read data
  always_comb
  begin
    s_d = s_q;
    // enable and divider in one write
    if (wr_int)
    begin
      s_d.int_en = reg_wdata[INT_EN_BIT];
      s_d.int_div = reg_wdata[INT_DIV_LSB +: 2];
    end
    s_d.int_rdy = s_q.int_en;
    // switch on the fly, no handshake
    if (wr_sel)
    begin
      s_d.src_sel = reg_wdata[SRC_SEL_BIT];
    end
    // frequency code is passed to the drive circuit
    if (wr_ext)
    begin
      s_d.ext_mode = reg_wdata[EXT_MODE_LSB +: 3];
      s_d.ext_freq = reg_wdata[EXT_FREQ_LSB +: 3];
    end
    // valid flag tracks settle detector, crystal mode only
    s_d.xtal_valid = ext_is_crystal(s_q.ext_mode) && ext_osc_settled;
    // circuit off gives no external clock
    // CMOS mode passes the pin through the pass ratio
    // peripherals see external clock whatever the selection
    s_d.periph_clk = ext_is_off(s_q.ext_mode) ? 1'b0 : ext_div_clk;
    // external only when select is 1
    // disabled internal oscillator gives a quiet clock
    if (s_q.src_sel)
    begin
      s_d.sysclk = ext_is_off(s_q.ext_mode) ? 1'b0 : ext_div_clk;
    end
    else
    begin
      s_d.sysclk = s_q.int_en ? int_div_clk : 1'b0;
    end
    // read data stand one cycle after the strobe, zero otherwise
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        INT_OSC_CTRL_OFF: s_d.rdata = {s_q.int_en, s_q.int_rdy, 4'h0, s_q.int_div};
        CLOCK_SELECT_OFF: s_d.rdata = {7'h00, s_q.src_sel};
        EXT_OSC_CTRL_OFF: s_d.rdata = {s_q.xtal_valid, s_q.ext_mode, 1'b0, s_q.ext_freq};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // reset returns to the internal source
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s_q <= ST_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s_q.rdata;
  assign sysclk_out = s_q.sysclk;
  assign periph_ext_clk = s_q.periph_clk;
  assign int_osc_enable = s_q.int_en;
  assign ext_osc_mode = s_q.ext_mode;
  assign ext_osc_freq_ctrl = s_q.ext_freq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_SRC_INTERNAL: assert property (
    !s_q.src_sel |=> sysclk_out == ($past(s_q.int_en) && $past(int_div_clk)))
    else $error("system clock not from internal source");

  AST_SRC_EXTERNAL: assert property (
    (s_q.src_sel && !ext_is_off(s_q.ext_mode)) |=> sysclk_out == $past(ext_div_clk))
    else $error("system clock not from external source");

  AST_PERIPH_KEPT: assert property (
    (!s_q.src_sel && !ext_is_off(s_q.ext_mode)) |=> periph_ext_clk == $past(ext_div_clk))
    else $error("peripheral clock lost while internal selected");

  AST_INT_WRITE: assert property (
    wr_int |=> int_osc_enable == $past(reg_wdata[7]) && s_q.int_div == $past(reg_wdata[1:0]))
    else $error("internal control write not applied");

  // flag must be set whether or not software looks, and a read then shows it
  AST_XTAL_VALID: assert property (
    (ext_is_crystal(s_q.ext_mode) && ext_osc_settled) |=> (s_q.xtal_valid and
      ((reg_rd && reg_addr == EXT_OSC_CTRL_OFF) |=> reg_rdata[7])))
    else $error("crystal valid flag not set");

  AST_XTAL_NOT_CRYSTAL: assert property (
    !ext_is_crystal(s_q.ext_mode) |=> !s_q.xtal_valid)
    else $error("crystal valid flag set outside crystal mode");

  AST_EXT_OFF: assert property (
    ext_is_off(s_q.ext_mode) |=> !periph_ext_clk)
    else $error("external clock present while circuit off");

  AST_CMOS_PASS: assert property (
    (ext_osc_mode == EXT_MODE_CMOS && $past(ext_osc_mode) == EXT_MODE_CMOS
      && $past(ext_osc_mode, 2) == EXT_MODE_CMOS) |-> periph_ext_clk == $past(ext_clock_pin_a, 3))
    else $error("cmos clock not passed undivided");

  AST_FREQ_WRITE: assert property (
    wr_ext |=> ext_osc_freq_ctrl == $past(reg_wdata[2:0]) && ext_osc_mode == $past(reg_wdata[6:4]))
    else $error("frequency control not applied");

  AST_RESET_INT: assert property (
    $rose(resetn) |-> !s_q.src_sel && int_osc_enable)
    else $error("reset did not select internal oscillator");

  AST_DIV_ONE: assert property (
    (s_q.int_div == 2'h3 && $past(s_q.int_div) == 2'h3) |-> int_div_clk == $past(int_osc_in, 2))
    else $error("divide by 1 path wrong");

  AST_INT_OFF: assert property (
    (!s_q.int_en && !s_q.src_sel) |=> !sysclk_out)
    else $error("system clock runs with internal oscillator off");

  // halved clock changes only three cycles after a sampled rise of the pin
  AST_HALF_STAGE: assert property (
    (ext_is_half($past(ext_osc_mode)) && ext_is_half($past(ext_osc_mode, 2))
      && ext_is_half($past(ext_osc_mode, 3)))
      |-> $changed(periph_ext_clk) == ($past(ext_clock_pin_a, 3) && !$past(ext_clock_pin_a, 4)))
    else $error("divide by 2 stage missing");

  COV_SWITCH_EXT: cover property (!s_q.src_sel ##1 s_q.src_sel);
  COV_XTAL_VALID: cover property ($rose(s_q.xtal_valid));
  COV_CMOS_HALF: cover property (ext_osc_mode == EXT_MODE_CMOS_HALF && $rose(periph_ext_clk));
  COV_INT_OFF: cover property (ext_osc_mode == EXT_MODE_OFF && !int_osc_enable);

endmodule

/* File: verilog/sysclk_sel_pkg.sv */
package sysclk_sel_pkg;

  // register byte offsets
  localparam logic [7:0] INT_OSC_CTRL_OFF = 8'h8A;
  localparam logic [7:0] CLOCK_SELECT_OFF = 8'h97;
  localparam logic [7:0] EXT_OSC_CTRL_OFF = 8'h8C;

  // reset values
  localparam logic [7:0] INT_OSC_CTRL_RST = 8'hC0;
  localparam logic [7:0] CLOCK_SELECT_RST = 8'h00;
  localparam logic [7:0] EXT_OSC_CTRL_RST = 8'h00;

  // field positions
  localparam int INT_EN_BIT = 7;
  localparam int INT_RDY_BIT = 6;
  localparam int INT_DIV_LSB = 0;
  localparam int SRC_SEL_BIT = 0;
  localparam int XTAL_VALID_BIT = 7;
  localparam int EXT_MODE_LSB = 4;
  localparam int EXT_FREQ_LSB = 0;

  // external oscillator mode codes
  localparam logic [2:0] EXT_MODE_OFF = 3'h0;
  localparam logic [2:0] EXT_MODE_CMOS = 3'h2;
  localparam logic [2:0] EXT_MODE_CMOS_HALF = 3'h3;

  // ratio select of the edge divider: 0 pass, 1 half, 2 quarter, 3 eighth
  localparam logic [1:0] RATIO_PASS = 2'h0;
  localparam logic [1:0] RATIO_HALF = 2'h1;

  // modes 000 and 001 leave the circuit off
  function automatic logic ext_is_off(input logic [2:0] mode);
    ext_is_off = (mode[2:1] == 2'h0);
  endfunction

  // odd codes other than 001 add the divide-by-2 stage
  function automatic logic ext_is_half(input logic [2:0] mode);
    ext_is_half = mode[0] && !ext_is_off(mode);
  endfunction

  function automatic logic ext_is_crystal(input logic [2:0] mode);
    ext_is_crystal = (mode[2:1] == 2'h3);
  endfunction

  // divider code 11 is divide by 1, 00 divide by 8
  function automatic logic [1:0] int_ratio(input logic [1:0] code);
    int_ratio = 2'h3 - code;
  endfunction

endpackage

/* File: verilog/clk_ratio_div.sv */
`timescale 1ns/1ps
module clk_ratio_div
  import sysclk_sel_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_in,
  input wire logic [1:0] ratio_sel,
  output logic clk_out
);

  typedef struct packed {
    logic in_q;
    logic [2:0] cnt_q;
    logic out_q;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // count rising edges of the sampled waveform; a count bit is the slower clock
  always_comb
  begin
    s_d = s_q;
    s_d.in_q = clk_in;
    if (clk_in && !s_q.in_q)
    begin
      s_d.cnt_q = s_q.cnt_q + 3'h1;
    end
    unique case (ratio_sel)
      2'h0: s_d.out_q = s_q.in_q;
      2'h1: s_d.out_q = s_q.cnt_q[0];
      2'h2: s_d.out_q = s_q.cnt_q[1];
      2'h3: s_d.out_q = s_q.cnt_q[2];
    endcase
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.out_q;

endmodule

/* File: bench/osc_partner.sv */
`timescale 1ns/1ps
module osc_partner
#(
  parameter int SETTLE_CYC = 20
)
(
  input wire logic core_clk,
  input wire logic [2:0] ext_osc_mode,
  output logic int_osc_in,
  output logic ext_clock_pin_a,
  output logic ext_osc_settled
);
  logic [1:0] ph_q = 2'h0;
  int settle_q = 0;

  // waveforms never stop, so any gating has to come from the block
  assign int_osc_in = ph_q[0];
  assign ext_clock_pin_a = ph_q[1];
  assign ext_osc_settled = (settle_q >= SETTLE_CYC);

  // bias settles only while crystal mode is held
  always @(posedge core_clk)
  begin
    ph_q <= ph_q + 2'h1;
    if (ext_osc_mode[2:1] != 2'h3)
      settle_q <= 0;
    else if (settle_q < SETTLE_CYC)
      settle_q <= settle_q + 1;
  end
endmodule

/* File: bench/system_clock_source_select_test.sv */
`timescale 1ns/1ps
module system_clock_source_select_test;
  import sysclk_sel_pkg::*;
  localparam int SETTLE = 20;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic int_osc_in, ext_clock_pin_a, ext_osc_settled;
  logic sysclk_out, periph_ext_clk, int_osc_enable;
  logic [2:0] ext_osc_mode, ext_osc_freq_ctrl;
  int n_mismatch = 0;
  int compares = 0;
  int n_sys, n_per;

  always #5 core_clk = ~core_clk;

  system_clock_source_select i_dut (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .int_osc_in(int_osc_in), .ext_clock_pin_a(ext_clock_pin_a),
    .ext_osc_settled(ext_osc_settled), .sysclk_out(sysclk_out),
    .periph_ext_clk(periph_ext_clk), .int_osc_enable(int_osc_enable),
    .ext_osc_mode(ext_osc_mode), .ext_osc_freq_ctrl(ext_osc_freq_ctrl));

  osc_partner #(.SETTLE_CYC(SETTLE)) i_osc (.core_clk(core_clk),
    .ext_osc_mode(ext_osc_mode), .int_osc_in(int_osc_in),
    .ext_clock_pin_a(ext_clock_pin_a), .ext_osc_settled(ext_osc_settled));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // edge counts drift by one with phase, so allow that much
  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got < exp - 1 || got > exp + (exp > 0))
    begin
      n_mismatch++;
      $display("[ERR] %0t edges %0d want %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask

  // let the clock path settle, then count rising edges over 64 cycles
  task automatic clk_chk(input int es, input int ep);
    logic ps, pp;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    n_sys = 0;
    n_per = 0;
    ps = sysclk_out;
    pp = periph_ext_clk;
    repeat (64)
    begin
      @(negedge core_clk);
      // an unknown would count as no edge and slip past an expected zero
      if ($isunknown({sysclk_out, periph_ext_clk}))
      begin
        n_mismatch++;
        $display("[ERR] %0t unknown clock output", $time);
      end
      n_sys += int'(sysclk_out & ~ps);
      n_per += int'(periph_ext_clk & ~pp);
      ps = sysclk_out;
      pp = periph_ext_clk;
    end
    chk_n(n_sys, es);
    chk_n(n_per, ep);
  endtask

  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(INT_OSC_CTRL_OFF, 8'hC0);
    rd(CLOCK_SELECT_OFF, 8'h00);
    rd(EXT_OSC_CTRL_OFF, 8'h00);
    rd(8'h00, 8'h00);
    clk_chk(4, 0);
    for (int c = 0; c < 4; c++)
    begin
      wr(INT_OSC_CTRL_OFF, 8'h80 | 8'(c));
      clk_chk(32 >> (3 - c), 0);
      rd(INT_OSC_CTRL_OFF, 8'hC0 | 8'(c));
    end
    wr(INT_OSC_CTRL_OFF, 8'h03);
    clk_chk(0, 0);
    chk({7'h00, int_osc_enable}, 8'h00);
    rd(INT_OSC_CTRL_OFF, 8'h03);
    wr(INT_OSC_CTRL_OFF, 8'h83);
    // every mode, with the read-only valid bit written as 1
    for (int m = 0; m < 8; m++)
    begin
      wr(EXT_OSC_CTRL_OFF, {1'b1, 3'(m), 1'b0, 3'(m)});
      clk_chk(32, (m < 2) ? 0 : ((m % 2) ? 8 : 16));
      chk({2'h0, ext_osc_mode, ext_osc_freq_ctrl}, {2'h0, 3'(m), 3'(m)});
      rd(EXT_OSC_CTRL_OFF, {m >= 6, 3'(m), 1'b0, 3'(m)});
    end
    // an early look at the valid flag must not show it set
    wr(EXT_OSC_CTRL_OFF, 8'h00);
    wr(EXT_OSC_CTRL_OFF, 8'h62);
    rd(EXT_OSC_CTRL_OFF, 8'h62);
    repeat (2 * SETTLE) @(posedge core_clk);
    rd(EXT_OSC_CTRL_OFF, 8'hE2);
    wr(CLOCK_SELECT_OFF, 8'h01);
    clk_chk(16, 16);
    rd(CLOCK_SELECT_OFF, 8'h01);
    wr(EXT_OSC_CTRL_OFF, 8'h00);
    clk_chk(0, 0);
    // an RC network is used at once, with the external source still selected
    wr(EXT_OSC_CTRL_OFF, 8'h42);
    clk_chk(16, 16);
    wr(CLOCK_SELECT_OFF, 8'h00);
    clk_chk(32, 16);
    stop_test();
  end

  // hang guard, far beyond the roughly 1500 cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
